// ---- dv/sdram_burst_read_checker.sv ----
// Port checker for the burst read sequencer.
module sdram_burst_read_checker
  import sdram_read_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Request side
  input wire logic req_valid_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic req_ready_out,
  input wire logic rd_valid_out,
  input wire logic rd_done_out,
  // Memory pins
  input wire logic cs_n_out,
  input wire logic row_strobe_upper_n_out,
  input wire logic row_strobe_lower_n_out,
  input wire logic col_strobe_upper_n_out,
  input wire logic col_strobe_lower_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Command decode
  // ----
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic rw_h, cl_h, take, act, rdc, nop;
  logic [2:0] rcnt_q, vcnt_q;
  logic side_q;
  assign rw_h = row_strobe_upper_n_out && row_strobe_lower_n_out;
  assign cl_h = col_strobe_upper_n_out && col_strobe_lower_n_out;
  assign take = req_valid_in && req_ready_out;
  assign act = !cs_n_out && !rw_h && cl_h;
  assign rdc = !cs_n_out && rw_h && !cl_h;
  assign nop = !cs_n_out && rw_h && cl_h;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rcnt_q <= 3'h0;
      vcnt_q <= 3'h0;
    end else if (take) begin
      rcnt_q <= 3'h0;
      vcnt_q <= 3'h0;
    end else begin
      rcnt_q <= rcnt_q + 3'(rdc);
      vcnt_q <= vcnt_q + 3'(rd_valid_out);
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      side_q <= 1'b0;
    end else if (take) begin
      side_q <= req_addr_in[UPPER_AREA_BIT];
    end
  end
  // ----
  // Properties
  // ----
  property p_act;
    take |=> act && row_strobe_upper_n_out ==
      !$past(req_addr_in[UPPER_AREA_BIT]);
  endproperty
  a_act: assert property (p_act) else $error("bad activate");
  property p_gap;
    act || nop |=> nop || rdc;
  endproperty
  a_gap: assert property (p_gap) else $error("bad filler");
  property p_dly;
    act |-> ##[1:4] rdc;
  endproperty
  a_dly: assert property (p_dly) else $error("late read");
  property p_reads;
    rdc && rcnt_q < 3'h3 |=> rdc;
  endproperty
  a_reads: assert property (p_reads) else $error("read gap");
  property p_quiet;
    rcnt_q == 3'h4 |-> cs_n_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("cmd in wait");
  property p_done;
    rd_done_out |-> rcnt_q == 3'h4 && vcnt_q == 3'h4 && req_ready_out;
  endproperty
  a_done: assert property (p_done) else $error("bad count");
  property p_excl;
    (row_strobe_upper_n_out || row_strobe_lower_n_out) &&
      (col_strobe_upper_n_out || col_strobe_lower_n_out);
  endproperty
  a_excl: assert property (p_excl) else $error("two strobes");
  property p_busy;
    take |=> !req_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready early");
  property p_side;
    rdc |-> col_strobe_upper_n_out == !side_q;
  endproperty
  a_side: assert property (p_side) else $error("wrong column pair");
endmodule

bind sdram_burst_read sdram_burst_read_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clock_in, .rst_n_in, .req_valid_in, .req_addr_in, .req_ready_out,
  .rd_valid_out, .rd_done_out, .cs_n_out, .row_strobe_upper_n_out,
  .row_strobe_lower_n_out, .col_strobe_upper_n_out, .col_strobe_lower_n_out);

// ---- dv/sdram_burst_read_tb.sv ----
// Self-checking bench for the burst read sequencer.
module sdram_burst_read_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_read_pkg::*;
  `define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
  // ----
  // Signals and instances
  // ----
  int bad_count = 0, check_count = 0, cyc = 0;
  logic clock_in = 1'b0, rst_n_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, req_valid_in = 1'b0;
  logic req_area3_in = 1'b0;
  logic [1:0] lat = 2'h1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rd_data_out, mem_data_in;
  logic [25:0] req_addr_in = 26'h0, mem_addr_out;
  logic req_ready_out, rd_valid_out, rd_done_out, cs_n_out, we_n_out;
  logic row_strobe_upper_n_out, row_strobe_lower_n_out;
  logic col_strobe_upper_n_out, col_strobe_lower_n_out;
  sdram_burst_read u_dut (.clock_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .req_valid_in, .req_addr_in,
    .req_area3_in, .req_ready_out, .rd_data_out, .rd_valid_out, .rd_done_out,
    .mem_addr_out, .cs_n_out, .row_strobe_upper_n_out, .row_strobe_lower_n_out,
    .col_strobe_upper_n_out, .col_strobe_lower_n_out, .we_n_out, .mem_data_in);
  sdram_model u_mem (.clock_in, .cs_n_in(cs_n_out),
    .row_n_in(row_strobe_upper_n_out & row_strobe_lower_n_out),
    .col_n_in(col_strobe_upper_n_out & col_strobe_lower_n_out),
    .we_n_in(we_n_out), .addr_in(mem_addr_out[15:0]), .lat_in(lat),
    .data_out(mem_data_in));
  always #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ----
  // Helpers
  // ----
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 `CHK("rdata", e, reg_rdata_out)
  endtask
  // Expected pins, low sixteen, for row or column phase of a beat.
  function automatic logic [15:0] pins(logic [25:0] a, logic b32,
      logic [3:0] s, logic c, logic [1:0] bt);
    logic ap;
    ap = c && bt == 2'h3;
    if (c && b32) a[3:2] = a[3:2] + bt;
    if (c && !b32) a[2:1] = a[2:1] + bt;
    if (!c && !b32 && s == MUX_2M_X16) return {a[24:10], a[0]};
    if (!c) return {a[23:9], a[0]};
    if (b32) return {a[23:22], a[13], ap, a[11:0]};
    if (s == MUX_2M_X16) return {a[24:22], a[12], ap, a[10:0]};
    return {a[15], a[22:21], a[12], ap, a[10:0]};
  endfunction
  task automatic burst(logic [8:0] mc, logic [3:0] wc, logic [25:0] a,
      logic a3);
    int r = mc[5:4] + 1, p = mc[7:6] + 1, n = 0, last = 0;
    int l = a3 ? wc[3:2] : wc[1:0];
    logic [15:0] row = pins(a, mc[8], mc[3:0], 1'b0, 2'h0);
    bit fin = 0;
    if (l == 0) l = 1;
    wr(MEM_CTRL_OFS, 32'(mc));
    wr(WAIT_CTRL_OFS, 32'(wc));
    lat <= 2'(l);
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_addr_in <= a;
    req_area3_in <= a3;
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    for (int t = 1; t < 60 && !fin; t++) begin
      #1;
      if (rd_valid_out === 1'b1) begin
        if (n == 0) `CHK("first", r + l + 2, t)
        `CHK("word", {row, pins(a, mc[8], mc[3:0], 1'b1, 2'(n))}, rd_data_out)
        last = t;
        n++;
      end
      if (rd_done_out === 1'b1) begin
        `CHK("gap", last + p, t)
        `CHK("beats", 4, n)
        fin = 1;
      end
      @(posedge clock_in);
    end
    `CHK("fin", 1'b1, fin)
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd(MEM_CTRL_OFS, 32'h104);
    rd(WAIT_CTRL_OFS, 32'hf);
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h0);
    rd(STATUS_OFS, 32'h0);
  endtask
  task automatic t_burst32();
    for (int d = 0; d < 4; d++) begin
      burst({1'b1, 2'(d), 2'(d), MUX_1M_X16}, 4'h5, 26'h2f5a7cb, 1'b0);
    end
  endtask
  task automatic t_lat();
    for (int l = 0; l < 4; l++) begin
      burst({1'b1, 4'h1, MUX_1M_X16}, {2'(l), 2'h2}, 26'h0a35e74, 1'b1);
    end
    burst({1'b1, 4'h0, MUX_1M_X16}, 4'h6, 26'h0a35e74, 1'b0);
  endtask
  task automatic t_bus16();
    burst({1'b0, 4'h2, MUX_2M_X16}, 4'h5, 26'h3c9b5a7, 1'b1);
    burst({1'b0, 4'h8, MUX_1M_X16}, 4'h5, 26'h1d24c3b, 1'b0);
  endtask
  task automatic t_reset();
    rst_n_in <= 1'b0;
    @(posedge clock_in);
    #1 `CHK("ready", 1'b1, req_ready_out)
    `CHK("cs", 1'b1, cs_n_out)
    `CHK("addr", 26'h0, mem_addr_out)
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(MEM_CTRL_OFS, 32'h104);
    rd(WAIT_CTRL_OFS, 32'hf);
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_burst32();
    t_lat();
    t_bus16();
    t_reset();
    end_of_test();
  end
endmodule

// ---- dv/sdram_model.sv ----
// Behavioural model of the synchronous DRAM on the memory pins.
module sdram_model (
  // Clock and command
  input wire logic clock_in,
  input wire logic cs_n_in,
  input wire logic row_n_in,
  input wire logic col_n_in,
  input wire logic we_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [1:0] lat_in,
  // Read data
  output logic [31:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Command decode and latency pipe
  // ----
  logic [15:0] row_q;
  logic [2:0] vld_q = 3'h0;
  logic [31:0] pipe_q [3];
  logic rd;
  logic [1:0] k;
  assign rd = !cs_n_in && row_n_in && !col_n_in && we_n_in;
  assign k = lat_in - 2'h1;
  always @(posedge clock_in) begin
    if (!cs_n_in && !row_n_in) begin
      row_q <= addr_in;
    end
    vld_q <= {vld_q[1:0], rd};
    pipe_q[0] <= {row_q, addr_in};
    pipe_q[1] <= pipe_q[0];
    pipe_q[2] <= pipe_q[1];
  end
  // Stale words are inverted so a mistimed capture cannot pass by luck.
  assign data_out = vld_q[k] ? pipe_q[k] : ~pipe_q[k];
endmodule

// ---- rtl/sdram_burst_read.sv ----
// Synchronous DRAM address multiplexer and four-beat burst read sequencer.

// Overview of operation
// - 16-bit bus, selector 0101: column A1-A10,flag,A12,A22-A24; row A10-A24.
// - 16-bit bus, selector 0100: column A1-A10,flag,A12,A21,A22,A15; row A9-A23.
// - 32-bit bus, selector 0100: pins A15/A14 carry A23/A22 in both phases.
// - 32-bit bus, selector 0100: row A10-A21 on A2-A13, column A2-A11, A13.
// - Column phase drives the memory A10 pin low or high for precharge choice.
// - Upper 32 Mbytes use the upper strobe pair, lower use the lower pair.
// - Activate, three reads, read with auto-precharge, four captured words.
// - Memory runs burst length one, so each read returns one word.
// - After the fourth word is captured wait precharge field plus one cycles, issuing nothing.
// - Activate-to-command field values 0 to 3 give 1 to 4 cycles.
// - Extra activate-to-command cycles drive a no-operation command.
// - Read-to-data latency of 1 to 3 cycles matches the CAS latency.
// - Address bits A25-A16 and A0 always pass through unchanged.
// - Areas 2 and 3 each hold their own latency field.
module sdram_burst_read
  import sdram_read_pkg::*;
#(
  parameter int ADDR_W = 26,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Read request port
  input wire logic req_valid_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic req_area3_in,
  output logic req_ready_out,
  output logic [DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic rd_done_out,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic cs_n_out,
  output logic row_strobe_upper_n_out,
  output logic row_strobe_lower_n_out,
  output logic col_strobe_upper_n_out,
  output logic col_strobe_lower_n_out,
  output logic we_n_out,
  input wire logic [DATA_W-1:0] mem_data_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic [8:0] mem_ctrl;
    logic [3:0] wait_ctrl;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic upper;
    logic [1:0] lat;
    logic [2:0] cnt;
    logic [1:0] beat;
    logic [3:0] pipe;
    logic [2:0] got;
    logic [ADDR_W-1:0] pin_addr;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [DATA_W-1:0] data;
    logic valid;
    logic done;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{
    st: ST_IDLE,
    mem_ctrl: MEM_CTRL_RST,
    wait_ctrl: WAIT_CTRL_RST,
    rdata: 32'h0,
    addr: '0,
    upper: 1'b0,
    lat: 2'h1,
    cnt: 3'h0,
    beat: 2'h0,
    pipe: 4'h0,
    got: 3'h0,
    pin_addr: '0,
    cs_n: 1'b1,
    ras_n: 1'b1,
    cas_n: 1'b1,
    we_n: 1'b1,
    data: '0,
    valid: 1'b0,
    done: 1'b0
  };

  ctrl_t q;
  ctrl_t d;

  // ----------------------------------------------------------------
  // Address multiplexing
  // ----------------------------------------------------------------
  // Pins not named per selector keep the plain address, so the
  // never-multiplexed high bits and A0 need no separate path.
  function automatic logic [ADDR_W-1:0] mux_addr(
    input logic [ADDR_W-1:0] a,
    input logic [3:0] sel,
    input logic bus32,
    input logic col,
    input logic ap
  );
    logic [ADDR_W-1:0] m;
    m = a;
    if (bus32 && sel == MUX_1M_X16) begin
      if (col) begin
        m[12] = ap;
      end else begin
        m[13:1] = a[21:9];
      end
      m[14] = a[22];
      m[15] = a[23];
    end else if (!bus32 && sel == MUX_2M_X16) begin
      if (col) begin
        m[11] = ap;
        m[12] = a[12];
        m[15:13] = a[24:22];
      end else begin
        m[15:1] = a[24:10];
      end
    end else if (!bus32 && sel == MUX_1M_X16) begin
      if (col) begin
        m[11] = ap;
        m[13] = a[21];
        m[14] = a[22];
        m[15] = a[15];
      end else begin
        m[15:1] = a[23:9];
      end
    end
    // Other codes fall through unmultiplexed.
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [3:0] sel;
  logic bus32;
  logic [1:0] act_dly;
  logic [1:0] pre_wait;
  logic [1:0] lat_field;
  logic [ADDR_W-1:0] col_base;
  logic issue;
  logic [1:0] issue_beat;

  assign sel = q.mem_ctrl[MUX_SEL_LSB +: 4];
  assign bus32 = q.mem_ctrl[BUS32_BIT];
  assign act_dly = q.mem_ctrl[ACT_DLY_LSB +: 2];
  assign pre_wait = q.mem_ctrl[PRE_WAIT_LSB +: 2];
  assign lat_field = req_area3_in ? q.wait_ctrl[AREA3_LAT_LSB +: 2]
                                  : q.wait_ctrl[AREA2_LAT_LSB +: 2];

  always_comb begin
    d = q;
    issue = 1'b0;
    issue_beat = 2'h0;
    col_base = q.addr;
    d.done = 1'b0;
    d.cs_n = 1'b1;
    d.ras_n = 1'b1;
    d.cas_n = 1'b1;
    d.we_n = 1'b1;
    // Latency pipe: bit 0 marks the cycle in which data is latched.
    // A read enters at bit lat, so its word lands lat cycles after it.
    d.pipe = {1'b0, q.pipe[3:1]};
    d.valid = q.pipe[0];
    if (q.pipe[0]) begin
      d.data = mem_data_in;
      d.got = q.got + 3'h1;
    end

    // Register port; read data stand only in the following cycle.
    d.rdata = 32'h0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        MEM_CTRL_OFS: d.mem_ctrl = reg_wdata_in[8:0];
        WAIT_CTRL_OFS: d.wait_ctrl = reg_wdata_in[3:0];
        default: d.mem_ctrl = d.mem_ctrl;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        MEM_CTRL_OFS: d.rdata = {23'h0, q.mem_ctrl};
        WAIT_CTRL_OFS: d.rdata = {28'h0, q.wait_ctrl};
        STATUS_OFS: d.rdata = {29'h0, q.beat, q.st != ST_IDLE};
        default: d.rdata = 32'h0;
      endcase
    end

    case (q.st)
      ST_IDLE: begin
        if (req_valid_in) begin
          d.addr = req_addr_in;
          d.upper = req_addr_in[UPPER_AREA_BIT];
          d.lat = (lat_field == 2'h0) ? 2'h1 : lat_field;
          d.got = 3'h0;
          d.beat = 2'h0;
          d.st = ST_ACT;
          d.cs_n = 1'b0;
          d.ras_n = 1'b0;
          d.pin_addr = mux_addr(req_addr_in, sel, bus32, 1'b0,
                                NO_PRECHARGE_LVL);
        end
      end
      ST_ACT: begin
        if (act_dly == 2'h0) begin
          issue = 1'b1;
        end else begin
          d.st = ST_NOP;
          d.cnt = {1'b0, act_dly};
          d.cs_n = 1'b0;
        end
      end
      ST_NOP: begin
        d.cnt = q.cnt - 3'h1;
        if (q.cnt == 3'h1) begin
          issue = 1'b1;
        end else begin
          d.cs_n = 1'b0;
        end
      end
      ST_CMD: begin
        if (q.beat == LAST_BEAT) begin
          d.st = ST_DATA;
        end else begin
          issue = 1'b1;
          issue_beat = q.beat + 2'h1;
        end
      end
      ST_DATA: begin
        if (d.got == BEATS_DONE) begin
          d.st = ST_PRE;
          d.cnt = {1'b0, pre_wait} + 3'h1;
        end
      end
      ST_PRE: begin
        // Nothing reaches the memory until the precharge wait ends.
        d.cnt = q.cnt - 3'h1;
        if (q.cnt == 3'h1) begin
          d.st = ST_IDLE;
          d.done = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (issue) begin
      // Burst steps the low column bits with wraparound.
      if (bus32) begin
        col_base[3:2] = q.addr[3:2] + issue_beat;
      end else begin
        col_base[2:1] = q.addr[2:1] + issue_beat;
      end
      d.st = ST_CMD;
      d.beat = issue_beat;
      d.cs_n = 1'b0;
      d.cas_n = 1'b0;
      d.pin_addr = mux_addr(col_base, sel, bus32, 1'b1,
        (issue_beat == LAST_BEAT) ? PRECHARGE_LVL
                                  : NO_PRECHARGE_LVL);
      d.pipe[q.lat] = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready_out = (q.st == ST_IDLE);
  assign reg_rdata_out = q.rdata;
  assign rd_data_out = q.data;
  assign rd_valid_out = q.valid;
  assign rd_done_out = q.done;
  assign mem_addr_out = q.pin_addr;
  assign cs_n_out = q.cs_n;
  assign we_n_out = q.we_n;
  assign row_strobe_upper_n_out = q.ras_n | ~q.upper;
  assign row_strobe_lower_n_out = q.ras_n | q.upper;
  assign col_strobe_upper_n_out = q.cas_n | ~q.upper;
  assign col_strobe_lower_n_out = q.cas_n | q.upper;

endmodule

// ---- rtl/sdram_read_pkg.sv ----
// Constants and types for the synchronous DRAM burst read controller.
package sdram_read_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [7:0] MEM_CTRL_OFS = 8'h00;
  localparam logic [7:0] WAIT_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // memory_control_reg fields.
  localparam int MUX_SEL_LSB = 0;
  localparam int ACT_DLY_LSB = 4;
  localparam int PRE_WAIT_LSB = 6;
  localparam int BUS32_BIT = 8;
  localparam logic [8:0] MEM_CTRL_RST = 9'h104;

  // wait_control_reg_two fields.
  localparam int AREA2_LAT_LSB = 0;
  localparam int AREA3_LAT_LSB = 2;
  localparam logic [3:0] WAIT_CTRL_RST = 4'hf;

  // Status fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BEAT_LSB = 1;

  // ----------------------------------------------------------------
  // Multiplex selector codes and burst shape
  // ----------------------------------------------------------------
  localparam logic [3:0] MUX_1M_X16 = 4'h4;
  localparam logic [3:0] MUX_2M_X16 = 4'h5;
  localparam int BURST_BEATS = 4;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [2:0] BEATS_DONE = 3'h4;
  localparam int UPPER_AREA_BIT = 25;
  localparam logic PRECHARGE_LVL = 1'b1;
  localparam logic NO_PRECHARGE_LVL = 1'b0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACT = 6'h02,
    ST_NOP = 6'h04,
    ST_CMD = 6'h08,
    ST_DATA = 6'h10,
    ST_PRE = 6'h20
  } seq_state_t;

endpackage
